// ==== afe_mgmt.sv ====
`timescale 1ns/1ns

// Operation
// - FIFO flag at threshold plus one records
// - Mode 0 holds pulse until status read
// - Mode 1 self-clears after quarter period
// - Pulse every 1st, 2nd, 4th, 16th instant
// - Over-range beyond 2048 times threshold, 128ms
// - Under-range within 32 times threshold, 128ms
// - Threshold fields at 15:8 and 7:0
// - Dynamic writes leave FIFO and sync alone
// - Software reset restores power-on defaults
// - Commands need an all-zero payload
// - Sync starts on next master clock edge
// - Sync flushes FIFO, filter; keeps configuration (here sync only restarts divider, period, pulse flag and lead-off timers)
// - Registers at 0x04 and 0x05, read/write
// - Flags reach interrupt only when enabled
module afe_mgmt #(
   parameter int LEADOFF_CYCLES = afe_mgmt_pkg::LEADOFF_CYCLES,
   parameter int ADC_W = 20,
   parameter int PERIOD_W = 16,
   parameter int COUNT_W = 4,
   parameter int TIMER_W = 22
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sclk_i,
   input wire logic csb_n_i,
   input wire logic sdi_i,
   output logic sdo_o,
   output logic sdo_oe_o,
   input wire logic [COUNT_W-1:0] fifo_count_i,
   input wire logic sample_instant_i,
   input wire logic status_read_i,
   input wire logic adc_valid_i,
   input wire logic [ADC_W-1:0] adc_data_i,
   input wire logic [1:0] ac_leadoff_enable_i,
   input wire logic [afe_mgmt_pkg::NUM_FLAGS-1:0] irq_enable_i,
   output logic fifo_threshold_flag_o,
   output logic sample_sync_pulse_o,
   output logic overrange_flag_o,
   output logic underrange_flag_o,
   output logic irq_o,
   output logic sync_start_o,
   output logic soft_reset_o,
   output logic fast_recovery_clear_o
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [2:0] fifo_irq_threshold;
      logic fast_recovery_clear;
      logic sample_pulse_clear_mode;
      logic [1:0] sample_pulse_rate;
      logic [7:0] ac_overrange_threshold;
      logic [7:0] ac_underrange_threshold;
      logic [3:0] div_cnt;
      logic [PERIOD_W-1:0] gap_cnt;
      logic [PERIOD_W-1:0] period;
      logic [PERIOD_W-1:0] age;
      logic sample_flag;
      logic fifo_flag;
      logic over_cond;
      logic under_cond;
      logic [TIMER_W-1:0] over_timer;
      logic [TIMER_W-1:0] under_timer;
      logic over_flag;
      logic under_flag;
      logic irq;
      logic sync_pulse;
      logic reset_pulse;
   } mgmt_state_t;

   localparam mgmt_state_t RESET_STATE = '{
      fifo_irq_threshold: afe_mgmt_pkg::THR_RST,
      fast_recovery_clear: afe_mgmt_pkg::FAST_RST,
      sample_pulse_clear_mode: afe_mgmt_pkg::CLR_MODE_RST,
      sample_pulse_rate: afe_mgmt_pkg::RATE_RST,
      ac_overrange_threshold: afe_mgmt_pkg::OVR_RST,
      ac_underrange_threshold: afe_mgmt_pkg::UND_RST,
      default: '0
   };

   localparam logic [TIMER_W-1:0] TIMER_LIMIT = TIMER_W'(LEADOFF_CYCLES);
   localparam logic [TIMER_W-1:0] TIMER_ONE = TIMER_W'(1);
   localparam logic [PERIOD_W-1:0] PERIOD_ONE = PERIOD_W'(1);
   localparam logic [PERIOD_W-1:0] PERIOD_MAX = '1;
   localparam logic [3:0] DIV_ONE = 4'h1;

   mgmt_state_t q, d;
   logic [31:0] link_word;
   logic link_toggle;
   logic cmd_event;
   logic [23:0] int_image;
   logic [23:0] dyn_image;

   // ****************************************************************
   // Link side and crossing
   // ****************************************************************
   serial_link u_link (
      .sclk_i(sclk_i),
      .rst_i(rst_i),
      .csb_n_i(csb_n_i),
      .sdi_i(sdi_i),
      .int_reg_i(int_image),
      .dyn_reg_i(dyn_image),
      .sdo_o(sdo_o),
      .sdo_oe_o(sdo_oe_o),
      .word_o(link_word),
      .toggle_o(link_toggle)
   );

   // Word is held steady on the link side until after this event lands
   event_sync u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .toggle_i(link_toggle),
      .event_o(cmd_event)
   );

   // Readback images, unused positions read as zero
   always_comb begin
      int_image = '0;
      int_image[afe_mgmt_pkg::THR_MSB:afe_mgmt_pkg::THR_LSB] = q.fifo_irq_threshold;
      int_image[afe_mgmt_pkg::FAST_BIT] = q.fast_recovery_clear;
      int_image[afe_mgmt_pkg::CLR_MODE_BIT] = q.sample_pulse_clear_mode;
      int_image[afe_mgmt_pkg::RATE_MSB:afe_mgmt_pkg::RATE_LSB] = q.sample_pulse_rate;
      dyn_image = '0;
      dyn_image[afe_mgmt_pkg::OVR_MSB:afe_mgmt_pkg::OVR_LSB] = q.ac_overrange_threshold;
      dyn_image[afe_mgmt_pkg::UND_MSB:afe_mgmt_pkg::UND_LSB] = q.ac_underrange_threshold;
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      logic [6:0] addr;
      logic [23:0] payload;
      logic zero_payload;
      logic issue;
      logic [3:0] mask;
      logic [3:0] fifo_need;
      logic [PERIOD_W-1:0] quarter;
      logic signed [ADC_W:0] sample;
      logic signed [ADC_W:0] over_lim;
      logic signed [ADC_W:0] under_lim;
      logic [afe_mgmt_pkg::NUM_FLAGS-1:0] flags;
      addr = link_word[31:25];
      payload = link_word[23:0];
      zero_payload = (payload == afe_mgmt_pkg::ZERO_PAYLOAD);
      issue = 1'b0;
      mask = afe_mgmt_pkg::MASK_EVERY;
      fifo_need = '0;
      quarter = '0;
      sample = (ADC_W+1)'($signed(adc_data_i));
      over_lim = '0;
      under_lim = '0;
      flags = '0;
      d = q;
      d.sync_pulse = 1'b0;
      d.reset_pulse = 1'b0;

      // Register writes and commands from the link
      if (cmd_event) begin
         unique case (addr)
            afe_mgmt_pkg::ADDR_INT_MGR: begin
               d.fifo_irq_threshold = payload[afe_mgmt_pkg::THR_MSB:afe_mgmt_pkg::THR_LSB];
               d.fast_recovery_clear = payload[afe_mgmt_pkg::FAST_BIT];
               d.sample_pulse_clear_mode = payload[afe_mgmt_pkg::CLR_MODE_BIT];
               d.sample_pulse_rate = payload[afe_mgmt_pkg::RATE_MSB:afe_mgmt_pkg::RATE_LSB];
            end
            // No flush and no sync: dynamic settings apply on the fly
            afe_mgmt_pkg::ADDR_DYN_MGR: begin
               d.ac_overrange_threshold = payload[afe_mgmt_pkg::OVR_MSB:afe_mgmt_pkg::OVR_LSB];
               d.ac_underrange_threshold = payload[afe_mgmt_pkg::UND_MSB:afe_mgmt_pkg::UND_LSB];
            end
            afe_mgmt_pkg::ADDR_SW_RESET: d.reset_pulse = zero_payload;
            afe_mgmt_pkg::ADDR_SYNC_CMD: d.sync_pulse = zero_payload;
            default: d.reset_pulse = 1'b0;
         endcase
      end

      // Sample pulse divider and data period measurement
      unique case (q.sample_pulse_rate)
         afe_mgmt_pkg::RATE_EVERY: mask = afe_mgmt_pkg::MASK_EVERY;
         afe_mgmt_pkg::RATE_2ND: mask = afe_mgmt_pkg::MASK_2ND;
         afe_mgmt_pkg::RATE_4TH: mask = afe_mgmt_pkg::MASK_4TH;
         afe_mgmt_pkg::RATE_16TH: mask = afe_mgmt_pkg::MASK_16TH;
      endcase
      if (q.gap_cnt != PERIOD_MAX) begin
         d.gap_cnt = q.gap_cnt + PERIOD_ONE;
      end
      if (sample_instant_i) begin
         issue = ((q.div_cnt & mask) == '0);
         d.div_cnt = q.div_cnt + DIV_ONE;
         d.period = d.gap_cnt;
         d.gap_cnt = '0;
      end

      // Pulse flag: set wins over either kind of clear
      quarter = q.period >> afe_mgmt_pkg::QUARTER_SHIFT;
      if (quarter == '0) begin
         quarter = PERIOD_ONE;
      end
      if (q.age != PERIOD_MAX) begin
         d.age = q.age + PERIOD_ONE;
      end
      if (issue) begin
         d.sample_flag = 1'b1;
         d.age = '0;
      end else if (q.sample_pulse_clear_mode && d.age >= quarter) begin
         d.sample_flag = 1'b0;
      end else if (!q.sample_pulse_clear_mode && status_read_i) begin
         d.sample_flag = 1'b0;
      end

      // FIFO threshold: code n means n+1 unread records
      fifo_need = 4'(q.fifo_irq_threshold) + DIV_ONE;
      d.fifo_flag = (4'(fifo_count_i) >= fifo_need);

      // Lead-off window test on each converter result
      over_lim = (ADC_W+1)'((ADC_W+1)'(q.ac_overrange_threshold) << afe_mgmt_pkg::OVR_SHIFT);
      under_lim = (ADC_W+1)'((ADC_W+1)'(q.ac_underrange_threshold) << afe_mgmt_pkg::UND_SHIFT);
      if (adc_valid_i) begin
         d.over_cond = (sample > over_lim) || (sample < -over_lim);
         d.under_cond = (sample <= under_lim) && (sample >= -under_lim);
      end
      if (!ac_leadoff_enable_i[1]) begin
         d.over_cond = 1'b0;
         d.under_cond = 1'b0;
      end

      // Persistence timers; flags latch until status read, set wins
      d.over_timer = q.over_cond ? q.over_timer : '0;
      d.under_timer = q.under_cond ? q.under_timer : '0;
      if (q.over_cond && q.over_timer != TIMER_LIMIT) begin
         d.over_timer = q.over_timer + TIMER_ONE;
      end
      if (q.under_cond && q.under_timer != TIMER_LIMIT) begin
         d.under_timer = q.under_timer + TIMER_ONE;
      end
      if (status_read_i) begin
         d.over_flag = 1'b0;
         d.under_flag = 1'b0;
      end
      if (q.over_cond && q.over_timer == TIMER_LIMIT) begin
         d.over_flag = 1'b1;
      end
      if (q.under_cond && q.under_timer == TIMER_LIMIT) begin
         d.under_flag = 1'b1;
      end

      // Interrupt term gated per flag
      flags[afe_mgmt_pkg::FLAG_FIFO] = q.fifo_flag;
      flags[afe_mgmt_pkg::FLAG_SAMPLE] = q.sample_flag;
      flags[afe_mgmt_pkg::FLAG_OVER] = q.over_flag;
      flags[afe_mgmt_pkg::FLAG_UNDER] = q.under_flag;
      d.irq = |(flags & irq_enable_i);

      // Sync restarts timing but leaves all settings intact
      if (d.sync_pulse) begin
         d.div_cnt = '0;
         d.gap_cnt = '0;
         d.age = '0;
         d.sample_flag = 1'b0;
         d.over_timer = '0;
         d.under_timer = '0;
      end

      // Software reset behaves like power-on for everything here except its own pulse, which is set
      if (d.reset_pulse) begin
         d = RESET_STATE;
         d.reset_pulse = 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= RESET_STATE;
      end else begin
         q <= d;
      end
   end

   // ****************************************************************
   // Outputs, all from state flops
   // ****************************************************************
   assign fifo_threshold_flag_o = q.fifo_flag;
   assign sample_sync_pulse_o = q.sample_flag;
   assign overrange_flag_o = q.over_flag;
   assign underrange_flag_o = q.under_flag;
   assign irq_o = q.irq;
   assign sync_start_o = q.sync_pulse;
   assign soft_reset_o = q.reset_pulse;
   assign fast_recovery_clear_o = q.fast_recovery_clear;

endmodule

// ==== afe_mgmt_pkg.sv ====
package afe_mgmt_pkg;

   // ****************************************************************
   // Register addresses (7-bit command field of a frame)
   // ****************************************************************
   localparam logic [6:0] ADDR_INT_MGR = 7'h04;
   localparam logic [6:0] ADDR_DYN_MGR = 7'h05;
   localparam logic [6:0] ADDR_SW_RESET = 7'h08;
   localparam logic [6:0] ADDR_SYNC_CMD = 7'h09;

   // ****************************************************************
   // Frame layout: 7 address bits, 1 read bit, 24 data bits
   // ****************************************************************
   localparam int DATA_W = 24;
   localparam int FRAME_W = 32;
   localparam logic [4:0] CNT_LAST_CMD = 5'h07;
   localparam logic [4:0] CNT_LAST_BIT = 5'h1F;
   localparam logic [4:0] CNT_ONE = 5'h01;
   localparam logic READ_FLAG = 1'b1;
   localparam logic [23:0] ZERO_PAYLOAD = 24'h000000;

   // ****************************************************************
   // Interrupt manager fields and reset values
   // ****************************************************************
   localparam int THR_LSB = 16;
   localparam int THR_MSB = 18;
   localparam int FAST_BIT = 14;
   localparam int CLR_MODE_BIT = 2;
   localparam int RATE_LSB = 0;
   localparam int RATE_MSB = 1;
   localparam logic [2:0] THR_RST = 3'h3;
   localparam logic FAST_RST = 1'b0;
   localparam logic CLR_MODE_RST = 1'b1;
   localparam logic [1:0] RATE_RST = 2'h0;

   // Pulse rate codes and the divider masks they select
   localparam logic [1:0] RATE_EVERY = 2'h0;
   localparam logic [1:0] RATE_2ND = 2'h1;
   localparam logic [1:0] RATE_4TH = 2'h2;
   localparam logic [1:0] RATE_16TH = 2'h3;
   localparam logic [3:0] MASK_EVERY = 4'h0;
   localparam logic [3:0] MASK_2ND = 4'h1;
   localparam logic [3:0] MASK_4TH = 4'h3;
   localparam logic [3:0] MASK_16TH = 4'hF;

   // ****************************************************************
   // Dynamic mode fields and reset values
   // ****************************************************************
   localparam int OVR_LSB = 8;
   localparam int OVR_MSB = 15;
   localparam int UND_LSB = 0;
   localparam int UND_MSB = 7;
   localparam logic [7:0] OVR_RST = 8'hFF;
   localparam logic [7:0] UND_RST = 8'hFF;
   localparam int OVR_SHIFT = 11;
   localparam int UND_SHIFT = 5;
   localparam int QUARTER_SHIFT = 2;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_KHZ = 25000;
   localparam int LEADOFF_TIME_MS = 128;
   localparam int LEADOFF_CYCLES = LEADOFF_TIME_MS * CLK_KHZ;

   // ****************************************************************
   // Flag positions in the interrupt enable vector
   // ****************************************************************
   localparam int FLAG_FIFO = 0;
   localparam int FLAG_SAMPLE = 1;
   localparam int FLAG_OVER = 2;
   localparam int FLAG_UNDER = 3;
   localparam int NUM_FLAGS = 4;

endpackage

// ==== afe_mgmt_sva.sv ====
`timescale 1ns/1ns

// ****************************************************************
// Port checker for the management block
// ****************************************************************
module afe_mgmt_sva #(
   parameter int LEADOFF_CYCLES = 20,
   parameter int COUNT_W = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [COUNT_W-1:0] fifo_count_i,
   input wire logic sample_instant_i,
   input wire logic status_read_i,
   input wire logic [1:0] ac_leadoff_enable_i,
   input wire logic [afe_mgmt_pkg::NUM_FLAGS-1:0] irq_enable_i,
   input wire logic fifo_threshold_flag_o,
   input wire logic sample_sync_pulse_o,
   input wire logic overrange_flag_o,
   input wire logic underrange_flag_o,
   input wire logic irq_o,
   input wire logic sync_start_o,
   input wire logic soft_reset_o
);
   logic [3:0] fl;
   logic [31:0] en_q;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Flags in enable-vector order
   assign fl = {underrange_flag_o, overrange_flag_o, sample_sync_pulse_o, fifo_threshold_flag_o};

   // Cycles with lead-off checking enabled; saturates so it cannot wrap
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) en_q <= 32'h0;
      else if (!ac_leadoff_enable_i[1]) en_q <= 32'h0;
      else if (en_q < 32'hFFFFFFFF) en_q <= en_q + 32'h1;
   end

   a_fifo_full: assert property (fifo_count_i == 8 |=> fifo_threshold_flag_o)
      else $error("fifo flag low with eight records");
   a_fifo_empty: assert property (fifo_count_i == 0 |=> !fifo_threshold_flag_o)
      else $error("fifo flag high with no records");
   a_irq_or_term: assert property (irq_o == |($past(fl) & $past(irq_enable_i)))
      else $error("irq differs from enabled flags");
   a_sync_one_cycle: assert property (sync_start_o |=> !sync_start_o)
      else $error("sync pulse longer than one cycle");
   a_reset_one_cycle: assert property (soft_reset_o |=> !soft_reset_o)
      else $error("soft reset pulse longer than one cycle");
   a_over_sticky: assert property
      (overrange_flag_o && !status_read_i |=> overrange_flag_o || soft_reset_o)
      else $error("over-range flag dropped without read");
   a_over_time: assert property ($rose(overrange_flag_o) |-> en_q >= LEADOFF_CYCLES)
      else $error("over-range flag too early");
   a_under_time: assert property ($rose(underrange_flag_o) |-> en_q >= LEADOFF_CYCLES)
      else $error("under-range flag too early");
   a_sample_cause: assert property ($rose(sample_sync_pulse_o) |-> $past(sample_instant_i))
      else $error("sample flag without instant");
endmodule

bind afe_mgmt afe_mgmt_sva #(.LEADOFF_CYCLES(LEADOFF_CYCLES), .COUNT_W(COUNT_W)) chk (
   .clk_i(clk_i), .rst_i(rst_i), .fifo_count_i(fifo_count_i),
   .sample_instant_i(sample_instant_i), .status_read_i(status_read_i),
   .ac_leadoff_enable_i(ac_leadoff_enable_i), .irq_enable_i(irq_enable_i),
   .fifo_threshold_flag_o(fifo_threshold_flag_o), .sample_sync_pulse_o(sample_sync_pulse_o),
   .overrange_flag_o(overrange_flag_o), .underrange_flag_o(underrange_flag_o),
   .irq_o(irq_o), .sync_start_o(sync_start_o), .soft_reset_o(soft_reset_o));

// ==== afe_mgmt_tb_top.sv ====
`timescale 1ns/1ns

module afe_mgmt_tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic sclk, csb_n, sdi, sdo, sdo_oe;
   logic [3:0] fifo_count = 4'h0;
   logic sample_instant = 1'b0, status_read = 1'b0, adc_valid = 1'b0;
   logic [19:0] adc_data = 20'h00000;
   logic [1:0] lo_en = 2'h0;
   logic [3:0] irq_en = 4'h0;
   logic fifo_flag, sample_sync_pulse, over, under, irq, sync_start, soft_reset, fast;
   logic [23:0] rd;
   int mismatches = 0, checked = 0, syncs = 0, resets = 0, sync_exp = 0, seed, dv;
   int thrs[3] = '{0, 7, 3};

   // ****************************************************************
   // Design, host and clock
   // ****************************************************************
   afe_mgmt #(.LEADOFF_CYCLES(20)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .csb_n_i(csb_n), .sdi_i(sdi),
      .sdo_o(sdo), .sdo_oe_o(sdo_oe), .fifo_count_i(fifo_count),
      .sample_instant_i(sample_instant), .status_read_i(status_read),
      .adc_valid_i(adc_valid), .adc_data_i(adc_data), .ac_leadoff_enable_i(lo_en),
      .irq_enable_i(irq_en), .fifo_threshold_flag_o(fifo_flag), .sample_sync_pulse_o(sample_sync_pulse),
      .overrange_flag_o(over), .underrange_flag_o(under), .irq_o(irq),
      .sync_start_o(sync_start), .soft_reset_o(soft_reset), .fast_recovery_clear_o(fast));
   host_spi host (.sclk_o(sclk), .csb_n_o(csb_n), .sdi_o(sdi), .sdo_i(sdo), .sdo_oe_i(sdo_oe));

   // Master clock, 40 ns
   always #20 clk_i = ~clk_i;

   // Count command pulses mid-cycle, clear of the edge that launches them
   always @(negedge clk_i) begin
      if (sync_start === 1'b1) syncs++;
      if (soft_reset === 1'b1) resets++;
   end

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task chk(input logic [23:0] seen, input logic [23:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   // Write, then allow the crossing its 3..5 cycles plus margin
   task wr(input logic [6:0] a, input logic [23:0] d);
      host.xfer(a, 1'b0, d, rd);
      cyc(8);
   endtask

   task rdr(input logic [6:0] a, input logic [23:0] exp);
      host.xfer(a, 1'b1, 24'h000000, rd);
      chk(rd, exp);
   endtask

   task pulse_read();
      status_read = 1'b1;
      cyc(1);
      status_read = 1'b0;
      cyc(2);
   endtask

   task ichk(input logic [3:0] fl);
      chk(24'(irq), 24'(|(fl & irq_en)));
   endtask

   // Twenty converter results: 0 boundary 2048, 1 over, 2 under
   task feed(input int kind);
      int v;
      for (int i = 0; i < 20; i++) begin
         v = kind == 1 ? 2049 + ($random(seed) & 32'h3FF) : kind == 2 ? $random(seed) % 33 : 2048;
         if (kind != 2 && $random(seed) % 2 == 0) v = -v;
         adc_data = v[19:0];
         adc_valid = 1'b1;
         cyc(1);
         adc_valid = 1'b0;
         cyc(1);
      end
   endtask

   task end_sim();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Hang guard
   initial begin
      repeat (100000) @(posedge clk_i);
      mismatches++;
      end_sim();
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      seed = 57964;
      host.tick();
      cyc(2);
      rst_i = 1'b0;
      cyc(2);
      rdr(afe_mgmt_pkg::ADDR_INT_MGR, 24'h030004);
      rdr(afe_mgmt_pkg::ADDR_DYN_MGR, 24'h00FFFF);
      rdr(7'h06, 24'h000000);
      wr(afe_mgmt_pkg::ADDR_INT_MGR, 24'hFFFFFF);
      rdr(afe_mgmt_pkg::ADDR_INT_MGR, 24'h074007);
      chk(24'(fast), 24'h000001);
      wr(afe_mgmt_pkg::ADDR_DYN_MGR, 24'hFFA5C3);
      rdr(afe_mgmt_pkg::ADDR_DYN_MGR, 24'h00A5C3);
      chk(24'(syncs), 24'h000000);
      // Threshold sweep over record counts 0 to 8
      for (int t = 0; t < 3; t++) begin
         wr(afe_mgmt_pkg::ADDR_INT_MGR, {5'h00, 3'(thrs[t]), 16'h0004});
         for (int n = 0; n <= 8; n++) begin
            fifo_count = 4'(n);
            irq_en = 4'($random(seed));
            cyc(3);
            chk(24'(fifo_flag), 24'(n >= thrs[t] + 1));
            ichk({3'b000, 1'(n >= thrs[t] + 1)});
         end
      end
      fifo_count = 4'h0;
      // Every rate code, held until status read
      for (int r = 0; r < 4; r++) begin
         dv = r == 3 ? 16 : 1 << r;
         wr(afe_mgmt_pkg::ADDR_INT_MGR, 24'(r));
         wr(afe_mgmt_pkg::ADDR_SYNC_CMD, 24'h000000);
         sync_exp++;
         for (int n = 0; n < 17; n++) begin
            sample_instant = 1'b1;
            cyc(1);
            sample_instant = 1'b0;
            cyc(20);
            chk(24'(sample_sync_pulse), 24'(n % dv == 0));
            pulse_read();
            chk(24'(sample_sync_pulse), 24'h000000);
         end
      end
      chk(24'(syncs), 24'(sync_exp));
      rdr(afe_mgmt_pkg::ADDR_INT_MGR, 24'h000003);
      wr(afe_mgmt_pkg::ADDR_SYNC_CMD, 24'h000100);
      chk(24'(syncs), 24'(sync_exp));
      // Self-clearing flag, instants every 40 cycles
      wr(afe_mgmt_pkg::ADDR_INT_MGR, 24'h004004);
      chk(24'(fast), 24'h000001);
      for (int n = 0; n < 4; n++) begin
         sample_instant = 1'b1;
         cyc(1);
         sample_instant = 1'b0;
         cyc(4);
         if (n >= 2) chk(24'(sample_sync_pulse), 24'h000001);
         cyc(20);
         if (n >= 2) chk(24'(sample_sync_pulse), 24'h000000);
         cyc(15);
      end
      // Lead-off range checks with 2048 and 32 thresholds
      wr(afe_mgmt_pkg::ADDR_DYN_MGR, 24'h000101);
      irq_en = 4'($random(seed));
      lo_en = 2'b01;
      feed(1);
      chk(24'(over), 24'h000000);
      lo_en = 2'b10;
      feed(0);
      chk(24'({over, under}), 24'h000000);
      feed(1);
      chk(24'({over, under}), 24'h000002);
      ichk(4'b0100);
      feed(2);
      chk(24'({over, under}), 24'h000003);
      ichk(4'b1100);
      feed(0);
      pulse_read();
      chk(24'({over, under}), 24'h000000);
      lo_en = 2'b00;
      // Software reset, refused then taken
      wr(afe_mgmt_pkg::ADDR_SW_RESET, 24'h000001);
      chk(24'(resets), 24'h000000);
      rdr(afe_mgmt_pkg::ADDR_DYN_MGR, 24'h000101);
      wr(afe_mgmt_pkg::ADDR_SW_RESET, 24'h000000);
      chk(24'(resets), 24'h000001);
      chk(24'(fast), 24'h000000);
      rdr(afe_mgmt_pkg::ADDR_INT_MGR, 24'h030004);
      rdr(afe_mgmt_pkg::ADDR_DYN_MGR, 24'h00FFFF);
      end_sim();
   end
endmodule

// ==== event_sync.sv ====
`timescale 1ns/1ns

// ****************************************************************
// Toggle event crossing into the local clock domain
// ****************************************************************
module event_sync (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic toggle_i,
   output logic event_o
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic stable;
      logic event_out;
   } sync_state_t;

   sync_state_t q, d;

   // A change counts only once stages two and three agree
   always_comb begin
      d = q;
      d.s1 = toggle_i;
      d.s2 = q.s1;
      d.s3 = q.s2;
      d.event_out = 1'b0;
      if (q.s2 == q.s3 && q.s3 != q.stable) begin
         d.stable = q.s3;
         d.event_out = 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign event_o = q.event_out;

endmodule

// ==== host_spi.sv ====
`timescale 1ns/1ns

// ****************************************************************
// Host side of the serial register link
// ****************************************************************
module host_spi (
   output logic sclk_o,
   output logic csb_n_o,
   output logic sdi_o,
   input wire logic sdo_i,
   input wire logic sdo_oe_i
);
   // Link clock idles low, frame closed
   initial begin
      sclk_o = 1'b0;
      csb_n_o = 1'b1;
      sdi_o = 1'b0;
   end

   // One clock pulse with the frame closed, used during reset
   task tick();
      #6 sclk_o = 1'b1;
      #6 sclk_o = 1'b0;
   endtask

   // Whole 32-bit frame, data set on falling, read just before rising
   task xfer(input logic [6:0] addr, input logic rd, input logic [23:0] data,
             output logic [23:0] rdata);
      logic [31:0] w;
      w = {addr, rd, data};
      rdata = 24'h000000;
      csb_n_o = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         sdi_o = w[i];
         #6;
         if (i < 24) rdata[i] = sdo_oe_i ? sdo_i : 1'bx;
         sclk_o = 1'b1;
         #6 sclk_o = 1'b0;
      end
      #6 csb_n_o = 1'b1;
      sdi_o = ~sdi_o; // Released line must not show the last bit
      #12;
   endtask
endmodule

// ==== serial_link.sv ====
`timescale 1ns/1ns

// ****************************************************************
// 32-clock serial frame on the link clock
// ****************************************************************
module serial_link (
   input wire logic sclk_i,
   input wire logic rst_i,
   input wire logic csb_n_i,
   input wire logic sdi_i,
   input wire logic [23:0] int_reg_i,
   input wire logic [23:0] dyn_reg_i,
   output logic sdo_o,
   output logic sdo_oe_o,
   output logic [31:0] word_o,
   output logic toggle_o
);

   typedef struct packed {
      logic [4:0] cnt;
      logic [30:0] sr;
      logic [23:0] rd_sr;
   } frame_state_t;

   typedef struct packed {
      logic [31:0] word;
      logic tog;
   } hold_state_t;

   frame_state_t fq, fd;
   hold_state_t hq, hd;
   logic frame_rst;
   logic sdo_q;
   logic oe_q;

   // Link clock may stop outside frames, so chip select clears the frame
   assign frame_rst = rst_i | csb_n_i;

   // Shift in, load read data after the command byte, hand over writes
   always_comb begin
      logic [7:0] cmd;
      logic [31:0] full;
      cmd = {fq.sr[6:0], sdi_i};
      full = {fq.sr, sdi_i};
      fd = fq;
      hd = hq;
      fd.sr = full[30:0];
      fd.cnt = fq.cnt + afe_mgmt_pkg::CNT_ONE;
      fd.rd_sr = {fq.rd_sr[22:0], 1'b0};
      if (fq.cnt == afe_mgmt_pkg::CNT_LAST_CMD) begin
         unique case (cmd[7:1])
            afe_mgmt_pkg::ADDR_INT_MGR: fd.rd_sr = int_reg_i;
            afe_mgmt_pkg::ADDR_DYN_MGR: fd.rd_sr = dyn_reg_i;
            default: fd.rd_sr = '0;
         endcase
      end
      // Word is frozen until the next write, long after the far side sampled it
      if (fq.cnt == afe_mgmt_pkg::CNT_LAST_BIT && full[24] != afe_mgmt_pkg::READ_FLAG) begin
         hd.word = full;
         hd.tog = ~hq.tog;
      end
   end

   always_ff @(posedge sclk_i or posedge frame_rst) begin
      if (frame_rst) begin
         fq <= '0;
      end else begin
         fq <= fd;
      end
   end

   always_ff @(posedge sclk_i or posedge rst_i) begin
      if (rst_i) begin
         hq <= '0;
      end else begin
         hq <= hd;
      end
   end

   // Output changes on falling edges so the host samples a settled bit
   always_ff @(negedge sclk_i or posedge frame_rst) begin
      if (frame_rst) begin
         sdo_q <= 1'b0;
         oe_q <= 1'b0;
      end else begin
         sdo_q <= fq.rd_sr[23];
         oe_q <= 1'b1;
      end
   end

   assign sdo_o = sdo_q;
   assign sdo_oe_o = oe_q;
   assign word_o = hq.word;
   assign toggle_o = hq.tog;

endmodule
